/* design/link_setup_map.vh */
/*
 Constants for the serial slave link setup controller.
 Assumes word-wide access to the device's command block memory.
*/
`ifndef LINK_SETUP_MAP_VH
`define LINK_SETUP_MAP_VH
// Command block word offsets in device memory
`define W_ERROR 4'h0
`define W_COMMAND 4'h1
`define W_LINK_ID 4'h2
`define W_HANDLER 4'h3
`define W_PORT 4'h4
`define W_RATE 4'h5
`define W_CHARLEN 4'h6
`define W_PARITY 4'h7
`define W_STOP 4'h8
`define W_FLOW 4'h9
`define W_OPTION 4'ha
`define W_NODE 4'hb
`define W_RSVD 4'hc
`define W_COIL 4'hd
`define W_BASE_HI 4'he
`define W_BASE_LO 4'hf
// Own control registers, after the 16 staging words
`define R_CTRL 5'h10
`define R_STATUS 5'h11
`define R_DEV_ERR 5'h12
`define R_B5000_LO 5'h13
`define R_B5000_HI 5'h14
`define R_B3000_LO 5'h15
`define R_B3000_HI 5'h16
// Field values
`define CMD_CREATE 16'h0001
`define HANDLER_TEXT 16'h002b
`define HANDLER_BIN 16'h002a
`define LINK_ID_MIN 16'h4b15
`define LINK_ID_MAX 16'h4b63
`define PORT_MAX 16'h0004
`define PARITY_MAX 16'h0002
`define NODE_MAX 16'h00f7
`define EOM_MAX_MS 16'h0064
// Option word bit positions (bit 0 is lsb)
`define OPT_EXT_ADDR 5
`define OPT_CUSTOM_EOM 4
`define OPT_WPROT 2
`define OPT_MODEM 0
// Address translation distances
`define OFS_5000 32'h0000_0fa0
`define OFS_3000 32'h0000_07d0
// Read-back latency through the input synchroniser
`define RD_WAIT 2'h3
// Local error codes
`define E_COMMAND 8'h01
`define E_LINK_ID 8'h02
`define E_HANDLER 8'h03
`define E_PORT 8'h04
`define E_RATE 8'h05
`define E_FORMAT 8'h06
`define E_FLOW 8'h07
`define E_NODE 8'h08
`define E_EOM 8'h09
`define E_RSVD 8'h0a
`define E_DEVICE 8'h0b
`endif

/* design/link_setup_host.v */
/*
 Host controller that stages a 16-word connection setup block, checks it,
 writes it into the device's word memory and triggers its execution.
 Assumes a device with a word write/read port, a trigger input and a busy
 output; device inputs are asynchronous and are synchronised here.
*/
//
// Functional notes
// - Custom end-of-message interval must exceed 3.5 character times.
// - Minimum custom interval: 64,32,16,8 ms, then 5 ms at 9600/19200.
// - Custom interval should be as short as reliability allows.
// - Bases above 65535 span words 14 and 15, else word 14 zero.
// - Host must trigger the device to fetch and execute the block.
// - Word 1 is the command code; 1 means connection setup.
// - Word 2 link identifier 19221..19299, not already used; only the range is checked here.
// - Word 3 value 43 selects the text-framed slave handler.
// - Word 4 selects port 1 through 4.
// - Word 5 line rate is one of seven listed rates.
// - Word 6 data bits 7 or 8; word 8 stop bits 1 or 2.
// - Word 7 parity: 0 none, 1 odd, 2 even.
// - Word 9 flow: 0, 1, 2, 4 or 6.
// - Word 11 node address 1 through 247.
`timescale 1ns/1ps
`default_nettype none
`include "link_setup_map.vh"
module link_setup_host #(
	parameter BLOCK_BASE = 16'h0000 // Block location in device memory
) (
	input wire i_clk_sys, // System clock
	input wire i_srst, // Synchronous reset, high
	input wire [4:0] i_addr, // Register address
	input wire [15:0] i_wdata, // Register write data
	input wire i_wr, // Write strobe
	input wire i_rd, // Read strobe
	output reg [15:0] o_rdata, // Read data, cycle after strobe
	output reg [15:0] o_mem_addr, // Device memory address
	output reg [15:0] o_mem_wdata, // Device memory write data
	output reg o_mem_we, // Device memory write
	output reg o_mem_re, // Device memory read
	input wire [15:0] i_mem_rdata, // Device memory read data, async
	output reg [15:0] o_slot_addr, // Command slot: block address
	output reg o_trig, // Command trigger
	output reg o_once, // Execute once per trigger
	input wire i_dev_busy, // Device command busy, async
	output reg o_link_up // Connection created
);
	localparam S_IDLE = 7'h01;
	localparam S_CHECK = 7'h02;
	localparam S_WRITE = 7'h04;
	localparam S_TRIG = 7'h08;
	localparam S_WAIT = 7'h10;
	localparam S_READ = 7'h20;
	localparam S_DONE = 7'h40;

	reg [15:0] blk_r [0:15];
	reg [6:0] state_r;
	reg [3:0] idx_r;
	reg [1:0] wait_r;
	reg [7:0] err_r;
	reg [15:0] dev_err_r;
	reg fail_r;
	reg busy_s1_r, busy_s2_r;
	reg [15:0] rd_s1_r, rd_s2_r;
	reg [7:0] chk_nxt;
	reg [15:0] eom_min;
	reg rate_ok;
	wire [31:0] base7000;
	wire [31:0] base5000;
	wire [31:0] base3000;
	wire [15:0] opt;
	wire ext_on;
	integer k;

	assign opt = blk_r[`W_OPTION];
	assign ext_on = opt[`OPT_EXT_ADDR];
	// Register 7000 base; high word zero for small bases
	assign base7000 = {blk_r[`W_BASE_HI], blk_r[`W_BASE_LO]};
	assign base5000 = base7000 - `OFS_5000;
	assign base3000 = base5000 - `OFS_3000;

	// Minimum custom interval per line rate, zero means unsupported
	always @* begin
		rate_ok = 1'b1;
		eom_min = 16'h0000;
		case (blk_r[`W_RATE])
			16'd300: eom_min = 16'h0000;
			16'd600: eom_min = 16'h0040;
			16'd1200: eom_min = 16'h0020;
			16'd2400: eom_min = 16'h0010;
			16'd4800: eom_min = 16'h0008;
			16'd9600: eom_min = 16'h0005;
			16'd19200: eom_min = 16'h0005;
			default: rate_ok = 1'b0;
		endcase
	end

	// Block check, first failing field wins
	always @* begin
		chk_nxt = 8'h00;
		if (blk_r[`W_COMMAND] != `CMD_CREATE) begin
			chk_nxt = `E_COMMAND;
		end else if (blk_r[`W_LINK_ID] < `LINK_ID_MIN ||
			blk_r[`W_LINK_ID] > `LINK_ID_MAX) begin
			chk_nxt = `E_LINK_ID;
		end else if (blk_r[`W_HANDLER] != `HANDLER_TEXT &&
			blk_r[`W_HANDLER] != `HANDLER_BIN) begin
			chk_nxt = `E_HANDLER;
		end else if (blk_r[`W_PORT] == 16'h0000 ||
			blk_r[`W_PORT] > `PORT_MAX) begin
			chk_nxt = `E_PORT;
		end else if (!rate_ok) begin
			chk_nxt = `E_RATE;
		end else if ((blk_r[`W_CHARLEN] != 16'h0007 && blk_r[`W_CHARLEN] != 16'h0008) ||
			blk_r[`W_PARITY] > `PARITY_MAX ||
			(blk_r[`W_STOP] != 16'h0001 && blk_r[`W_STOP] != 16'h0002)) begin
			chk_nxt = `E_FORMAT;
		end else if (blk_r[`W_FLOW] != 16'h0000 && blk_r[`W_FLOW] != 16'h0001 &&
			blk_r[`W_FLOW] != 16'h0002 && blk_r[`W_FLOW] != 16'h0004 &&
			blk_r[`W_FLOW] != 16'h0006) begin
			chk_nxt = `E_FLOW;
		end else if (blk_r[`W_NODE] == 16'h0000 || blk_r[`W_NODE] > `NODE_MAX) begin
			chk_nxt = `E_NODE;
		end else if (blk_r[`W_HANDLER] == `HANDLER_TEXT) begin
			if (blk_r[`W_RSVD] != 16'h0000) begin
				chk_nxt = `E_RSVD;
			end
		end else if (opt[`OPT_CUSTOM_EOM]) begin
			// Interval must clear 3.5 characters and the rate table
			if (eom_min == 16'h0000 || blk_r[`W_RSVD] < eom_min ||
				blk_r[`W_RSVD] > `EOM_MAX_MS) begin
				chk_nxt = `E_EOM;
			end
		end
	end

	// Two-flop synchronisers for device inputs
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
			rd_s1_r <= 16'h0000;
			rd_s2_r <= 16'h0000;
		end else begin
			busy_s1_r <= i_dev_busy;
			busy_s2_r <= busy_s1_r;
			rd_s1_r <= i_mem_rdata;
			rd_s2_r <= rd_s1_r;
		end
	end

	// Staging words, written only while idle
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			for (k = 0; k < 16; k = k + 1) begin
				blk_r[k] <= 16'h0000;
			end
		end else if (i_wr && !i_addr[4] && state_r == S_IDLE) begin
			blk_r[i_addr[3:0]] <= i_wdata;
		end
	end

	// Register read port
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			if (!i_addr[4]) begin
				o_rdata <= blk_r[i_addr[3:0]];
			end else begin
				case (i_addr)
					`R_CTRL: o_rdata <= 16'h0000;
					`R_STATUS: o_rdata <= {err_r, 3'b000, ext_on, fail_r, o_link_up,
						state_r == S_DONE, state_r != S_IDLE && state_r != S_DONE};
					`R_DEV_ERR: o_rdata <= dev_err_r;
					`R_B5000_LO: o_rdata <= base5000[15:0];
					`R_B5000_HI: o_rdata <= base5000[31:16];
					`R_B3000_LO: o_rdata <= base3000[15:0];
					`R_B3000_HI: o_rdata <= base3000[31:16];
					default: o_rdata <= 16'h0000;
				endcase
			end
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// Setup sequence: check, copy block, trigger, collect result
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_r <= S_IDLE;
			idx_r <= 4'h0;
			wait_r <= 2'h0;
			err_r <= 8'h00;
			dev_err_r <= 16'h0000;
			fail_r <= 1'b0;
			o_mem_addr <= 16'h0000;
			o_mem_wdata <= 16'h0000;
			o_mem_we <= 1'b0;
			o_mem_re <= 1'b0;
			o_slot_addr <= 16'h0000;
			o_trig <= 1'b0;
			o_once <= 1'b0;
			o_link_up <= 1'b0;
		end else begin
			o_mem_we <= 1'b0;
			o_mem_re <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (i_wr && i_addr == `R_CTRL && i_wdata[0]) begin
						err_r <= 8'h00;
						fail_r <= 1'b0;
						dev_err_r <= 16'h0000;
						state_r <= S_CHECK;
					end
				end
				S_CHECK: begin
					if (chk_nxt != 8'h00) begin
						err_r <= chk_nxt;
						fail_r <= 1'b1;
						state_r <= S_DONE;
					end else begin
						idx_r <= 4'h0;
						state_r <= S_WRITE;
					end
				end
				S_WRITE: begin
					// Word 0 goes out cleared so a fault shows as nonzero
					o_mem_we <= 1'b1;
					o_mem_addr <= BLOCK_BASE + {12'h000, idx_r};
					o_mem_wdata <= (idx_r == `W_ERROR) ? 16'h0000 : blk_r[idx_r];
					idx_r <= idx_r + 4'h1;
					if (idx_r == 4'hf) begin
						state_r <= S_TRIG;
					end
				end
				S_TRIG: begin
					// Hold trigger until the device reports busy
					o_slot_addr <= BLOCK_BASE;
					o_trig <= 1'b1;
					o_once <= 1'b1;
					if (busy_s2_r) begin
						o_trig <= 1'b0;
						o_once <= 1'b0;
						state_r <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (!busy_s2_r) begin
						o_mem_re <= 1'b1;
						o_mem_addr <= BLOCK_BASE;
						wait_r <= `RD_WAIT;
						state_r <= S_READ;
					end
				end
				S_READ: begin
					// Result word read back through the synchroniser
					o_mem_re <= 1'b1;
					wait_r <= wait_r - 2'h1;
					if (wait_r == 2'h0) begin
						o_mem_re <= 1'b0;
						dev_err_r <= rd_s2_r;
						if (rd_s2_r != 16'h0000) begin
							err_r <= `E_DEVICE;
							fail_r <= 1'b1;
						end else begin
							o_link_up <= 1'b1;
						end
						state_r <= S_DONE;
					end
				end
				S_DONE: begin
					if (i_wr && i_addr == `R_CTRL && i_wdata[1]) begin
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* dv/link_dev_model.sv */
/*
 Behavioural device: 16-word command block memory, trigger and busy.
 Assumes the block sits at device word 0 and the host holds the trigger.
*/
`timescale 1ns/1ps
`default_nettype none
module link_dev_model (
	input wire logic clk, // Clock
	input wire logic [15:0] a, // Word address
	input wire logic [15:0] wd, // Write data
	input wire logic we, // Write
	input wire logic re, // Read enable
	input wire logic trig, // Command trigger
	input wire logic fail, // Force an execution fault
	output logic [15:0] rd, // Read data
	output logic busy // Command busy
);
	logic [15:0] mem [16];
	int cnt = 0;
	int nwr = 0;
	logic inst = 0; // Slave instance started
	initial foreach (mem[i]) mem[i] = 16'h0;
	// Released bus shows the inverse, never a stale word
	assign rd = re ? mem[a[3:0]] : ~mem[a[3:0]];
	assign busy = (cnt >= 4) && (cnt < 8);
	// Block store on any write, execution only after a trigger
	always @(posedge clk) begin
		if (we) begin
			mem[a[3:0]] <= wd;
			nwr <= nwr + 1;
		end
		if (trig && cnt == 0)
			cnt <= 1;
		else if (cnt != 0)
			cnt <= (cnt == 8) ? 0 : cnt + 1;
		if (cnt == 7) begin
			mem[0] <= (fail || mem[1] != 16'h0001) ? 16'h0b01 : 16'h0;
			inst <= !fail && mem[1] == 16'h0001;
		end
	end
endmodule
`default_nettype wire

/* dv/link_setup_host_properties.sv */
/*
 Port assertions for the setup host.
 Assumes the device model answers busy after each trigger.
*/
`timescale 1ns/1ps
`default_nettype none
module link_setup_host_properties #(
	parameter BLOCK_BASE = 16'h0000 // Block base
) (
	input wire logic i_clk_sys, i_srst, i_wr, i_rd, i_dev_busy, // Clock, reset, strobes
	input wire logic [4:0] i_addr, // Address
	input wire logic [15:0] i_wdata, i_mem_rdata, o_rdata, // Data
	input wire logic [15:0] o_mem_addr, o_mem_wdata, o_slot_addr, // Device side
	input wire logic o_mem_we, o_mem_re, o_trig, o_once, o_link_up // Device strobes
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// Offset of the word being written, all ones when idle
	wire [15:0] ws = o_mem_we ? o_mem_addr - BLOCK_BASE : 16'hffff;
	wire [15:0] w = o_mem_wdata;
	sequence burst; o_mem_we [*8] ##1 o_mem_we [*8]; endsequence
	sequence rback; o_mem_re [*4] ##1 !o_mem_re; endsequence
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0) else $error("rdata");
	a_trig_mode: assert property (o_trig == o_once) else $error("mode");
	a_slot_base: assert property (o_trig |-> o_slot_addr == BLOCK_BASE) else $error("slot");
	a_trig_hold: assert property ((o_trig && !i_dev_busy) [*3] |=> o_trig)
		else $error("trig dropped");
	a_trig_drop: assert property ($rose(i_dev_busy) |-> ##[1:4] !o_trig)
		else $error("trig held");
	a_block_burst: assert property (ws == 16'h0 |-> burst ##1 !o_mem_we ##[0:2] o_trig)
		else $error("burst");
	a_read_back: assert property ($rose(o_mem_re) |-> o_mem_addr == BLOCK_BASE ##0 rback)
		else $error("read back");
	a_link_keep: assert property (o_link_up |=> o_link_up) else $error("link");
	a_err_word: assert property (ws == 16'h0 |-> w == 16'h0) else $error("word0");
	a_cmd_word: assert property (ws == 16'h1 |-> w == 16'h1) else $error("cmd");
	a_hnd_word: assert property (ws == 16'h3 |-> w inside {16'h2a, 16'h2b})
		else $error("handler");
	a_port_word: assert property (ws == 16'h4 |-> w inside {[16'h1:16'h4]}) else $error("port");
	a_rate_word: assert property (ws == 16'h5 |-> w inside {16'h12c, 16'h258, 16'h4b0, 16'h960,
		16'h12c0, 16'h2580, 16'h4b00}) else $error("rate");
	a_node_word: assert property (ws == 16'hb |-> w inside {[16'h1:16'hf7]}) else $error("node");
endmodule
bind link_setup_host link_setup_host_properties #(.BLOCK_BASE(BLOCK_BASE)) chk_u (
	.i_clk_sys, .i_srst, .i_wr, .i_rd, .i_dev_busy, .i_addr, .i_wdata, .i_mem_rdata, .o_rdata,
	.o_mem_addr, .o_mem_wdata, .o_slot_addr, .o_mem_we, .o_mem_re, .o_trig, .o_once, .o_link_up);
`default_nettype wire

/* dv/testbench.sv */
/*
 Testbench: stages blocks through the register port and runs them.
 Assumes the device model at the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk_sys = 0, i_srst = 1, i_wr = 0, i_rd = 0, fail = 0;
	logic [4:0] i_addr = 5'h0;
	logic [15:0] i_wdata = 16'h0, rdv;
	wire [15:0] o_rdata, o_mem_addr, o_mem_wdata, o_slot_addr, mrd;
	wire o_mem_we, o_mem_re, o_trig, o_once, busy, o_link_up;
	int n_errors = 0, total_checks = 0, n0;
	logic [15:0] blk [16];
	logic [15:0] good [16] = '{16'h0, 16'h1, 16'h4b15, 16'h2b, 16'h1, 16'h2580, 16'h7, 16'h2,
		16'h1, 16'h6, 16'h20, 16'hf7, 16'h0, 16'h7d0, 16'h1, 16'h0};
	// Word, value, expected error code (0 accepted)
	logic [27:0] tbl [31] = '{28'h1000201, 28'h24b1402, 28'h24b6402, 28'h3002c03, 28'h4000004,
		28'h4000504, 28'h5012d05, 28'h6000906, 28'h7000306, 28'h8000306, 28'h9000307, 28'hb000008,
		28'hb00f808, 28'hc00010a, 28'h5012c00, 28'h5025800, 28'h504b000, 28'h5096000, 28'h512c000,
		28'h54b0000, 28'h6000800, 28'h7000000, 28'h7000100, 28'h8000200, 28'h9000000, 28'h9000100,
		28'h9000200, 28'h9000400, 28'h4000400, 28'hb000100, 28'h24b6300};
	initial forever #20 i_clk_sys = ~i_clk_sys;
	link_setup_host dut_u (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re), .i_mem_rdata(mrd),
		.o_slot_addr(o_slot_addr), .o_trig(o_trig), .o_once(o_once), .i_dev_busy(busy),
		.o_link_up(o_link_up));
	link_dev_model dev_u (.clk(i_clk_sys), .a(o_mem_addr), .wd(o_mem_wdata), .we(o_mem_we),
		.re(o_mem_re), .trig(o_trig), .fail(fail), .rd(mrd), .busy(busy));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write and read
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
	endtask
	// Stage blk, start, wait for done, check code and device traffic
	task go(input logic [7:0] code);
		wr(5'h10, 16'h2);
		for (int i = 0; i < 16; i++) wr(i[4:0], blk[i]);
		n0 = dev_u.nwr;
		wr(5'h10, 16'h1);
		// Forget the last run's done bit so polling starts afresh
		rdv = 16'h0;
		for (int k = 0; k < 100 && !rdv[1]; k++) rd(5'h11);
		chk(rdv & 16'hff0a, (code == 8'h0) ? 16'h0002 : {code, 8'h0a});
		chk(16'(dev_u.nwr - n0), (code == 8'h0 || code == 8'h0b) ? 16'd16 : 16'd0);
		$display("run done code %h", code);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		rd(5'h11);
		chk(rdv, 16'h0);
		rd(5'h1f);
		chk(rdv, 16'h0);
		$display("reset test done");
		// Field table, refusals before any accepted block
		foreach (tbl[j]) begin
			blk = good;
			blk[tbl[j][27:24]] = tbl[j][23:8];
			go(tbl[j][7:0]);
		end
		// Custom interval with the binary handler
		blk = good;
		blk[3] = 16'h2a;
		blk[10] = 16'h10;
		blk[5] = 16'h12c;
		blk[12] = 16'h5;
		go(8'h09);
		blk[5] = 16'h258;
		blk[12] = 16'h3f;
		go(8'h09);
		blk[12] = 16'h40;
		go(8'h00);
		blk = good;
		fail = 1'b1;
		go(8'h0b);
		fail = 1'b0;
		blk = good;
		go(8'h00);
		chk(rdv, 16'h0016);
		chk({15'h0, o_link_up}, 16'h1);
		rd(5'h13);
		chk(rdv, 16'hf060);
		rd(5'h14);
		chk(rdv, 16'h0);
		rd(5'h15);
		chk(rdv, 16'he890);
		rd(5'h16);
		chk(rdv, 16'h0);
		chk(dev_u.mem[13], 16'h7d0);
		chk(dev_u.mem[14], 16'h1);
		$display("address test done");
		end_sim;
	end
endmodule
`default_nettype wire
